// file: hdl/periph_irq_enable.sv
// Peripheral interrupt enable registers with AXI4-Lite access.
// Assumes flag inputs come from logic on the core clock; no synchronisers.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps

// How it works
// RULE1: Receiver request passes only when first bit5 set
// RULE2: Transmitter request passes only when first bit4 set
// RULE3: Sync serial request gated by first bit3
// RULE4: Period match request gated by first bit1
// RULE5: Wide timer overflow gated by first bit0
// RULE6: Nothing reaches core without master enable; IRQ_O stays up from already latched events while it is clear
// RULE7: Oscillator fail request gated by second bit7
// RULE8: Comparators B and A gated by bits6,5
// RULE9: Numeric oscillator request gated by second bit2
// RULE10: Unimplemented bits read zero; enables reset zero
module periph_irq_enable (
  // Clock and reset
  input  wire logic                                  CLK_SYS_I,
  input  wire logic                                  ARST_N_I,
  // AXI4-Lite write address and data
  input  wire logic                                  AWVALID_I,
  output logic                                       AWREADY_O,
  input  wire logic [periph_irq_enable_pkg::ADDR_W-1:0] AWADDR_I,
  input  wire logic                                  WVALID_I,
  output logic                                       WREADY_O,
  input  wire logic [periph_irq_enable_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic [3:0]                            WSTRB_I,
  // AXI4-Lite write response
  output logic                                       BVALID_O,
  input  wire logic                                  BREADY_I,
  output logic [1:0]                                 BRESP_O,
  // AXI4-Lite read
  input  wire logic                                  ARVALID_I,
  output logic                                       ARREADY_O,
  input  wire logic [periph_irq_enable_pkg::ADDR_W-1:0] ARADDR_I,
  output logic                                       RVALID_O,
  input  wire logic                                  RREADY_I,
  output logic [periph_irq_enable_pkg::DATA_W-1:0]   RDATA_O,
  output logic [1:0]                                 RRESP_O,
  // Peripheral flags in
  input  wire logic [periph_irq_enable_pkg::REG_W-1:0]  FLAGS_FIRST_I,
  input  wire logic [periph_irq_enable_pkg::REG_W-1:0]  FLAGS_SECOND_I,
  // Requests toward the core
  output logic [periph_irq_enable_pkg::REG_W-1:0]    GATED_FIRST_O,
  output logic [periph_irq_enable_pkg::REG_W-1:0]    GATED_SECOND_O,
  output logic                                       CORE_REQ_O,
  output logic                                       IRQ_O
);
  import periph_irq_enable_pkg::*;

  logic [REG_W-1:0]  en_first_r;
  logic [REG_W-1:0]  en_second_r;
  logic [REG_W-1:0]  ctrl_r;
  logic [REG_W-1:0]  evt_r;
  logic [REG_W-1:0]  evt_mask_r;
  logic [REG_W-1:0]  gated_first_r;
  logic [REG_W-1:0]  gated_second_r;
  logic              core_req_r;
  logic              irq_r;
  logic              any_first_r;
  logic              any_second_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r;
  logic [3:0]        w_strb_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0]        rresp_r;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_fire;
  logic              aw_full_nxt;
  logic              w_full_nxt;
  logic              bvalid_nxt;
  logic              rvalid_nxt;
  logic              wr_hit;
  logic              rd_hit;
  logic [REG_W-1:0]  rd_val;
  logic [REG_W-1:0]  gated_first_nxt;
  logic [REG_W-1:0]  gated_second_nxt;
  logic              master_en;
  logic              any_first_nxt;
  logic              any_second_nxt;
  logic [REG_W-1:0]  evt_set;
  logic [REG_W-1:0]  evt_clr;
  logic [REG_W-1:0]  evt_nxt;
  logic              lane0_wr;

  // Handshake terms
  assign aw_take     = AWVALID_I & awready_r;
  assign w_take      = WVALID_I & wready_r;
  assign ar_take     = ARVALID_I & arready_r;
  assign wr_fire     = aw_full_r & w_full_r & ~bvalid_r;
  assign aw_full_nxt = (aw_full_r | aw_take) & ~wr_fire;
  assign w_full_nxt  = (w_full_r | w_take) & ~wr_fire;
  assign bvalid_nxt  = (bvalid_r & ~BREADY_I) | wr_fire;
  assign rvalid_nxt  = (rvalid_r & ~RREADY_I) | ar_take;
  assign lane0_wr    = wr_fire & w_strb_r[0];

  // Write decode; only lane 0 carries register bits
  always_comb begin
    unique case (aw_addr_r)
      OFS_ENABLE_FIRST, OFS_ENABLE_SECOND, OFS_MAIN_CTRL,
      OFS_EVT_STATUS, OFS_EVT_MASK:                   wr_hit = 1'b1;
      default:                                        wr_hit = 1'b0;
    endcase
  end

  // Read mux; unimplemented bits come back as zero
  always_comb begin
    rd_hit = 1'b1;
    unique case (ARADDR_I)
      OFS_ENABLE_FIRST:  rd_val = en_first_r & FIRST_IMPL_MASK;    // [RULE10]
      OFS_ENABLE_SECOND: rd_val = en_second_r & SECOND_IMPL_MASK;  // [RULE10]
      OFS_MAIN_CTRL:     rd_val = ctrl_r;
      OFS_EVT_STATUS:    rd_val = evt_r;
      OFS_EVT_MASK:      rd_val = evt_mask_r;
      OFS_GATED_FIRST:   rd_val = gated_first_r;
      OFS_GATED_SECOND:  rd_val = gated_second_r;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Address and data holding; either may arrive first
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= 4'h0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      // Ready drops while a word is held so the slot is never overwritten
      awready_r <= ~aw_full_nxt & ~bvalid_nxt;
      wready_r  <= ~w_full_nxt & ~bvalid_nxt;
      if (aw_take) begin
        aw_addr_r <= AWADDR_I;
      end
      if (w_take) begin
        w_data_r <= WDATA_I;
        w_strb_r <= WSTRB_I;
      end
    end
  end

  // Write response
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      bvalid_r <= bvalid_nxt;
      if (wr_fire) begin
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel; data sampled at the address handshake
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_val};
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Enable registers; writes to unimplemented positions are dropped
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      en_first_r  <= ENABLE_RESET;  // [RULE10]
      en_second_r <= ENABLE_RESET;  // [RULE10]
    end else if (lane0_wr && aw_addr_r == OFS_ENABLE_FIRST) begin
      en_first_r <= w_data_r[REG_W-1:0] & FIRST_IMPL_MASK;  // [RULE10]
    end else if (lane0_wr && aw_addr_r == OFS_ENABLE_SECOND) begin
      en_second_r <= w_data_r[REG_W-1:0] & SECOND_IMPL_MASK;  // [RULE10]
    end
  end

  // Main control and event mask
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_r     <= CTRL_RESET;
      evt_mask_r <= EVT_RESET;
    end else if (lane0_wr && aw_addr_r == OFS_MAIN_CTRL) begin
      ctrl_r <= w_data_r[REG_W-1:0] & CTRL_IMPL_MASK;
    end else if (lane0_wr && aw_addr_r == OFS_EVT_MASK) begin
      evt_mask_r <= w_data_r[REG_W-1:0] & EVT_IMPL_MASK;
    end
  end

  // Per-source gating; the register bit position is the source index
  assign master_en = ctrl_r[PERIPH_MASTER_IRQ_ENABLE_BIT];
  genvar g;
  generate
    for (g = 0; g < REG_W; g++) begin : g_gate
      // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
      assign gated_first_nxt[g]  = FLAGS_FIRST_I[g] & en_first_r[g] & master_en;
      // [RULE7] [RULE8] [RULE9] [RULE6]
      assign gated_second_nxt[g] = FLAGS_SECOND_I[g] & en_second_r[g] & master_en;
    end
  endgenerate
  assign any_first_nxt  = |gated_first_nxt;
  assign any_second_nxt = |gated_second_nxt;

  // Registered requests; one cycle from flag to core
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gated_first_r  <= 8'h00;
      gated_second_r <= 8'h00;
      any_first_r    <= 1'b0;
      any_second_r   <= 1'b0;
      core_req_r     <= 1'b0;
    end else begin
      gated_first_r  <= gated_first_nxt;
      gated_second_r <= gated_second_nxt;
      any_first_r    <= any_first_nxt;
      any_second_r   <= any_second_nxt;
      core_req_r     <= any_first_nxt | any_second_nxt;  // [RULE6]
    end
  end

  // Sticky events on a new request per bank; set beats clear
  always_comb begin
    evt_set                 = 8'h00;
    evt_set[EVT_FIRST_BIT]  = any_first_nxt & ~any_first_r;
    evt_set[EVT_SECOND_BIT] = any_second_nxt & ~any_second_r;
    evt_clr                 = 8'h00;
    if (lane0_wr && aw_addr_r == OFS_EVT_STATUS) begin
      evt_clr = w_data_r[REG_W-1:0] & EVT_IMPL_MASK;
    end
    evt_nxt = (evt_r & ~evt_clr) | evt_set;
  end

  // Event status and level interrupt
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      evt_r <= EVT_RESET;
      irq_r <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      irq_r <= |(evt_nxt & evt_mask_r);
    end
  end

  // Outputs straight from flip-flops
  assign AWREADY_O      = awready_r;
  assign WREADY_O       = wready_r;
  assign BVALID_O       = bvalid_r;
  assign BRESP_O        = bresp_r;
  assign ARREADY_O      = arready_r;
  assign RVALID_O       = rvalid_r;
  assign RDATA_O        = rdata_r;
  assign RRESP_O        = rresp_r;
  assign GATED_FIRST_O  = gated_first_r;
  assign GATED_SECOND_O = gated_second_r;
  assign CORE_REQ_O     = core_req_r;
  assign IRQ_O          = irq_r;

  // Checks on the gating path, unimplemented-bit read-back and write response
  property p_rx_gate;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      FLAGS_FIRST_I[RX_IRQ_ENABLE_BIT] && en_first_r[RX_IRQ_ENABLE_BIT] && master_en
      |=> GATED_FIRST_O[RX_IRQ_ENABLE_BIT] && CORE_REQ_O;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("receiver request lost");  // [RULE1]

  property p_tx_block;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      !en_first_r[TX_IRQ_ENABLE_BIT] |=> !GATED_FIRST_O[TX_IRQ_ENABLE_BIT];
  endproperty
  a_tx_block: assert property (p_tx_block) else $error("transmitter request leaked");  // [RULE2]

  property p_sync_serial;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      GATED_FIRST_O[SYNC_SERIAL_IRQ_ENABLE_BIT]
      == $past(FLAGS_FIRST_I[SYNC_SERIAL_IRQ_ENABLE_BIT]
               & en_first_r[SYNC_SERIAL_IRQ_ENABLE_BIT] & master_en);
  endproperty
  a_sync_serial: assert property (p_sync_serial) else $error("sync serial gate wrong");  // [RULE3]

  property p_period_match;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      $rose(GATED_FIRST_O[PERIOD_MATCH_IRQ_ENABLE_BIT])
      |-> $past(en_first_r[PERIOD_MATCH_IRQ_ENABLE_BIT]);
  endproperty
  a_period_match: assert property (p_period_match) else $error("period match leaked");  // [RULE4]

  property p_wide_timer;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      (FLAGS_FIRST_I[WIDE_TIMER_OVERFLOW_IRQ_ENABLE_BIT] && master_en
       && en_first_r[WIDE_TIMER_OVERFLOW_IRQ_ENABLE_BIT])[*2]
      |=> GATED_FIRST_O[WIDE_TIMER_OVERFLOW_IRQ_ENABLE_BIT];
  endproperty
  a_wide_timer: assert property (p_wide_timer) else $error("overflow request lost");  // [RULE5]

  property p_master;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      !master_en |=> !CORE_REQ_O && GATED_FIRST_O == 8'h00 && GATED_SECOND_O == 8'h00;
  endproperty
  a_master: assert property (p_master) else $error("request passed without master");  // [RULE6]

  property p_osc_fail;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      GATED_SECOND_O[OSC_FAIL_IRQ_ENABLE_BIT]
      |-> $past(FLAGS_SECOND_I[OSC_FAIL_IRQ_ENABLE_BIT] && en_second_r[OSC_FAIL_IRQ_ENABLE_BIT]);
  endproperty
  a_osc_fail: assert property (p_osc_fail) else $error("osc fail gate wrong");  // [RULE7]

  property p_comparators;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      master_en && FLAGS_SECOND_I[COMPARATOR_B_IRQ_ENABLE_BIT]
      && FLAGS_SECOND_I[COMPARATOR_A_IRQ_ENABLE_BIT]
      |=> GATED_SECOND_O[COMPARATOR_B_IRQ_ENABLE_BIT] == $past(en_second_r[COMPARATOR_B_IRQ_ENABLE_BIT])
          && GATED_SECOND_O[COMPARATOR_A_IRQ_ENABLE_BIT]
             == $past(en_second_r[COMPARATOR_A_IRQ_ENABLE_BIT]);
  endproperty
  a_comparators: assert property (p_comparators) else $error("comparator gate wrong");  // [RULE8]

  property p_num_osc;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      !en_second_r[NUM_CTRL_OSC_IRQ_ENABLE_BIT] |=> !GATED_SECOND_O[NUM_CTRL_OSC_IRQ_ENABLE_BIT];
  endproperty
  a_num_osc: assert property (p_num_osc) else $error("numeric osc request leaked");  // [RULE9]

  property p_unimpl;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      ar_take && (ARADDR_I == OFS_ENABLE_FIRST || ARADDR_I == OFS_ENABLE_SECOND)
      |=> RVALID_O && RDATA_O[31:8] == 24'h000000
          && (RDATA_O[7:0] & ~($past(ARADDR_I) == OFS_ENABLE_FIRST ? FIRST_IMPL_MASK
                                                                  : SECOND_IMPL_MASK)) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read nonzero");  // [RULE10]

  property p_write_resp;
    @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
      wr_fire || (BVALID_O && !BREADY_I) |=> BVALID_O;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

  // Main scenarios
  c_rx_reaches:  cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
                   GATED_FIRST_O[RX_IRQ_ENABLE_BIT] && CORE_REQ_O);
  c_blocked:     cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
                   FLAGS_SECOND_I != 8'h00 && !master_en ##1 !CORE_REQ_O);
  c_irq:         cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I) $rose(IRQ_O));
  c_set_vs_clr:  cover property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
                   (evt_set & evt_clr) != 8'h00);

endmodule // periph_irq_enable

// file: hdl/periph_irq_enable_pkg.sv
// Constants for the peripheral interrupt enable block.
// Assumes an AXI4-Lite master with 32-bit data on the core clock.
package periph_irq_enable_pkg;

  // Bus geometry
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;
  localparam int          REG_W  = 8;

  // Register byte addresses
  localparam logic [7:0]  OFS_ENABLE_FIRST  = 8'h00;
  localparam logic [7:0]  OFS_ENABLE_SECOND = 8'h04;
  localparam logic [7:0]  OFS_MAIN_CTRL     = 8'h08;
  localparam logic [7:0]  OFS_EVT_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_EVT_MASK      = 8'h10;
  localparam logic [7:0]  OFS_GATED_FIRST   = 8'h14;
  localparam logic [7:0]  OFS_GATED_SECOND  = 8'h18;

  // Field positions, first enable register
  localparam int          GATE_ACQ_IRQ_ENABLE_BIT          = 7;
  localparam int          ADC_IRQ_ENABLE_BIT               = 6;
  localparam int          RX_IRQ_ENABLE_BIT                = 5;
  localparam int          TX_IRQ_ENABLE_BIT                = 4;
  localparam int          SYNC_SERIAL_IRQ_ENABLE_BIT       = 3;
  localparam int          PERIOD_MATCH_IRQ_ENABLE_BIT      = 1;
  localparam int          WIDE_TIMER_OVERFLOW_IRQ_ENABLE_BIT = 0;

  // Field positions, second enable register
  localparam int          OSC_FAIL_IRQ_ENABLE_BIT          = 7;
  localparam int          COMPARATOR_B_IRQ_ENABLE_BIT      = 6;
  localparam int          COMPARATOR_A_IRQ_ENABLE_BIT      = 5;
  localparam int          BUS_COLLISION_IRQ_ENABLE_BIT     = 3;
  localparam int          NUM_CTRL_OSC_IRQ_ENABLE_BIT      = 2;

  // Main control and event status fields
  localparam int          PERIPH_MASTER_IRQ_ENABLE_BIT     = 0;
  localparam int          EVT_FIRST_BIT                    = 0;
  localparam int          EVT_SECOND_BIT                   = 1;

  // Implemented-bit masks
  localparam logic [7:0]  FIRST_IMPL_MASK   = 8'hfb;
  localparam logic [7:0]  SECOND_IMPL_MASK  = 8'hec;
  localparam logic [7:0]  CTRL_IMPL_MASK    = 8'h01;
  localparam logic [7:0]  EVT_IMPL_MASK     = 8'h03;

  // Reset values
  localparam logic [7:0]  ENABLE_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [7:0]  EVT_RESET         = 8'h00;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

endpackage

// file: sim/peripheral_interrupt_enables_bench.sv
// Self-checking bench for the peripheral interrupt enable block.
// Assumes the design answers AXI4-Lite on one 250 MHz clock.
`timescale 1ns/10ps

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module peripheral_interrupt_enables_bench;
  import periph_irq_enable_pkg::*;

  // Clock, reset and bus wires
  logic        clk, arst_n;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  // Flags in, requests out
  logic [7:0]  flags_first, flags_second, gated_first, gated_second;
  logic        core_req, irq;
  int          err_count, checks_done;

  periph_irq_enable u_dut (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr),
    .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr),
    .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
    .FLAGS_FIRST_I(flags_first), .FLAGS_SECOND_I(flags_second),
    .GATED_FIRST_O(gated_first), .GATED_SECOND_O(gated_second),
    .CORE_REQ_O(core_req), .IRQ_O(irq)
  );

  // Core clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict and end of run
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A wait that ran out of its bound
  task automatic timeout();
    err_count++;
    close_out();
  endtask

  // One write; address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) timeout();
    `CHK(bresp, er)
    bready <= 1'b0;
  endtask

  // One read; data and response taken at the edge where rvalid is high
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 50) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) timeout();
    `CHK(rdata, ed)
    `CHK(rresp, er)
    rready <= 1'b0;
  endtask

  // Set an enable register, drive its bank's flags, sample after the one-cycle delay
  task automatic probe(input logic [7:0] ofs, input logic [7:0] en, input logic [7:0] fl,
                       output logic [7:0] got);
    axi_write(ofs, {24'h0, en}, 4'hf, RESP_OKAY);
    if (ofs == OFS_ENABLE_FIRST) flags_first <= fl;
    else flags_second <= fl;
    repeat (2) @(posedge clk);
    got = (ofs == OFS_ENABLE_FIRST) ? gated_first : gated_second;
  endtask

  // Interrupt line settles within a short bound
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n == 16) timeout();
    `CHK(irq, exp)
  endtask

  // Main sequence
  initial begin
    logic [7:0] got;
    logic [7:0] bitv;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    flags_first = 8'h00;
    flags_second = 8'h00;
    err_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, reserved bits, strobe and unmapped places
    for (int i = 0; i < 5; i++) axi_read(8'(4 * i), 32'h0, RESP_OKAY);
    axi_write(OFS_ENABLE_FIRST, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_read(OFS_ENABLE_FIRST, {24'h0, FIRST_IMPL_MASK}, RESP_OKAY);
    axi_write(OFS_ENABLE_SECOND, 32'hffff_ffff, 4'hf, RESP_OKAY);
    axi_read(OFS_ENABLE_SECOND, {24'h0, SECOND_IMPL_MASK}, RESP_OKAY);
    axi_write(OFS_ENABLE_FIRST, 32'h0, 4'he, RESP_OKAY);
    axi_read(OFS_ENABLE_FIRST, {24'h0, FIRST_IMPL_MASK}, RESP_OKAY);
    axi_write(8'h1c, 32'h1, 4'hf, RESP_SLVERR);
    axi_read(8'h1c, 32'h0, RESP_SLVERR);
    axi_write(OFS_GATED_FIRST, 32'hff, 4'hf, RESP_SLVERR);
    // Master enable still clear: nothing reaches the core
    probe(OFS_ENABLE_FIRST, 8'hff, 8'hff, got);
    `CHK(got, 8'h00)
    `CHK(core_req, 1'b0)
    axi_write(OFS_MAIN_CTRL, 32'h1, 4'hf, RESP_OKAY);
    // Each first-bank enable passes its own flag and no other
    for (int i = 0; i < 8; i++) begin
      bitv = 8'h01 << i;
      probe(OFS_ENABLE_FIRST, bitv, 8'hff, got);
      `CHK(got, bitv & FIRST_IMPL_MASK)
      `CHK(core_req, |(bitv & FIRST_IMPL_MASK))
      probe(OFS_ENABLE_FIRST, ~bitv, bitv, got);
      `CHK(got, 8'h00)
    end
    axi_read(OFS_GATED_FIRST, 32'h0, RESP_OKAY);
    flags_first <= 8'h00;
    // Same for the second bank
    for (int i = 0; i < 8; i++) begin
      bitv = 8'h01 << i;
      probe(OFS_ENABLE_SECOND, bitv, 8'hff, got);
      `CHK(got, bitv & SECOND_IMPL_MASK)
      `CHK(core_req, |(bitv & SECOND_IMPL_MASK))
      probe(OFS_ENABLE_SECOND, ~bitv, bitv, got);
      `CHK(got, 8'h00)
    end
    probe(OFS_ENABLE_SECOND, 8'h00, 8'h00, got);
    // Event status, mask and clear by writing one; the sweeps above left both bits set
    axi_write(OFS_EVT_STATUS, 32'h3, 4'hf, RESP_OKAY);
    axi_read(OFS_EVT_STATUS, 32'h0, RESP_OKAY);
    axi_write(OFS_EVT_MASK, 32'h3, 4'hf, RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    probe(OFS_ENABLE_FIRST, 8'h20, 8'h20, got);
    `CHK(got, 8'h20)
    wait_irq(1'b1);
    axi_read(OFS_EVT_STATUS, 32'h1, RESP_OKAY);
    axi_write(OFS_EVT_MASK, 32'h0, 4'hf, RESP_OKAY);
    wait_irq(1'b0);
    axi_write(OFS_EVT_STATUS, 32'h1, 4'hf, RESP_OKAY);
    axi_read(OFS_EVT_STATUS, 32'h0, RESP_OKAY);
    axi_write(OFS_EVT_MASK, 32'h3, 4'hf, RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    probe(OFS_ENABLE_SECOND, 8'h80, 8'h80, got);
    `CHK(got, 8'h80)
    wait_irq(1'b1);
    axi_read(OFS_EVT_STATUS, 32'h2, RESP_OKAY);
    // Second reset in mid-run clears the enables again
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    `CHK(core_req, 1'b0)
    `CHK(gated_second, 8'h00)
    arst_n <= 1'b1;
    axi_read(OFS_ENABLE_SECOND, 32'h0, RESP_OKAY);
    axi_read(OFS_EVT_STATUS, 32'h0, RESP_OKAY);
    axi_read(OFS_ENABLE_FIRST, 32'h0, RESP_OKAY);
    close_out();
  end
endmodule // peripheral_interrupt_enables_bench
